// *** rtl/mmit_pkg.sv ***
// Shared constants for the masked match interval timer
package mmit_pkg;

   // Counter, compare and mask width
   localparam int unsigned CNT_W       = 48;
   // Width of the low register half
   localparam int unsigned LOW_W       = 32;
   // Width of the high register half
   localparam int unsigned HIGH_W      = 16;
   // Register bus address and data widths
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned DATA_W      = 32;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_COMPARE_LOW      = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_IGNORE_BITS_LOW  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_TIMER_CONTROL    = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_COUNT_LOW        = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_COMPARE_HIGH     = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IGNORE_BITS_HIGH = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH       = 8'h1C;

   // Control register field positions
   localparam int unsigned CTRL_MATCH_FLAG_BIT      = 0;
   localparam int unsigned CTRL_CLEAR_ON_MATCH_BIT  = 1;
   localparam int unsigned CTRL_DEBUG_HALT_STOP_BIT = 2;
   localparam int unsigned CTRL_COUNT_ENABLE_BIT    = 3;

   // Reset values
   localparam logic [LOW_W-1:0]  RST_COMPARE_LOW      = 32'hFFFF_FFFF;
   localparam logic [HIGH_W-1:0] RST_COMPARE_HIGH     = 16'hFFFF;
   localparam logic [LOW_W-1:0]  RST_IGNORE_BITS_LOW  = 32'h0000_0000;
   localparam logic [HIGH_W-1:0] RST_IGNORE_BITS_HIGH = 16'h0000;
   localparam logic [CNT_W-1:0]  RST_COUNT            = 48'h0000_0000_0000;
   localparam logic              RST_MATCH_FLAG       = 1'b0;
   localparam logic              RST_CLEAR_ON_MATCH   = 1'b0;
   localparam logic              RST_DEBUG_HALT_STOP  = 1'b1;
   localparam logic              RST_COUNT_ENABLE     = 1'b1;

   // Counter step
   localparam logic [CNT_W-1:0]  CNT_STEP             = 48'h0000_0000_0001;

endpackage

// *** rtl/mmit_cmp_if.sv ***
// Connection between the timer core and its masked comparator
interface mmit_cmp_if
   import mmit_pkg::*;
();
   logic [CNT_W-1:0] count_value;         // Current counter
   logic [CNT_W-1:0] compare_value;       // Full compare value
   logic [CNT_W-1:0] compare_ignore_bits; // Mask, 1 forces a bit to match
   logic             match;               // All bits match after masking

   // Timer core supplies operands and reads the result
   modport core (output count_value, output compare_value,
                 output compare_ignore_bits, input match);
   // Comparator reads operands and returns the result
   modport cmp  (input count_value, input compare_value,
                 input compare_ignore_bits, output match);
endinterface

// *** rtl/mmit_masked_cmp.sv ***
// Masked equality comparator between counter and compare value
module mmit_masked_cmp
   import mmit_pkg::*;
(
   mmit_cmp_if.cmp cmp_bus
);

   logic [CNT_W-1:0] bit_ok; // Per-bit result after masking

   // Each bit matches when equal or when its mask bit is set
   always_comb begin
      bit_ok        = ~(cmp_bus.count_value ^ cmp_bus.compare_value)
                      | cmp_bus.compare_ignore_bits;
      cmp_bus.match = &bit_ok;
   end
endmodule

// *** rtl/masked_match_interval_timer.sv ***
// Top of the masked match interval timer with its register port
// What this block does
// - 48-bit up-counter on main clock, two halves
// - Counter free-runs or clears on match
// - Masked full match raises the interrupt
// - Mask one forces bit comparison true
// - Low compare bits 31:0, reset all ones
// - High compare at 0x010, reset 0xFFFF
// - Low mask at 0x004, reset zero
// - High mask at 0x014, reset zero
// - Low count at 0x00C, read/write, reset zero
// - High count at 0x01C, read/write, reset zero
// - Hardware sets match flag on match
// - Flag cleared by writing one, reset zero
// - Control bit 1 clears counter on match
// - Counter clear same edge as flag set
// - Control bit 2 stops count in halt
// - Control bit 3 enables counting
// - Enable and halt-stop both one after reset
// - Without clear, match leaves count sequence alone
// - All registers readable at any time
module masked_match_interval_timer
   import mmit_pkg::*;
(
   input  wire logic              clk_sys_i,    // Main clock, 100 MHz
   input  wire logic              srst_i,       // Synchronous reset, active high
   input  wire logic [ADDR_W-1:0] addr_i,       // Register byte address
   input  wire logic [DATA_W-1:0] wdata_i,      // Register write data
   input  wire logic              wr_i,         // Write strobe
   input  wire logic              rd_i,         // Read strobe
   input  wire logic              debug_halt_i, // Processor halted for debug
   output logic      [DATA_W-1:0] rdata_o,      // Read data, cycle after strobe
   output logic                   irq_o         // Interrupt, level of match flag
);

   // Whole state of the block
   typedef struct packed {
      logic [CNT_W-1:0]  compare_value;        // Compare value
      logic [CNT_W-1:0]  compare_ignore_bits;  // Compare mask
      logic [CNT_W-1:0]  count;                // Up-counter
      logic              match_flag;           // Sticky match flag
      logic              clear_on_match;       // Clear counter on match
      logic              debug_halt_stop;      // Stop counting in debug halt
      logic              count_enable;         // Counting enabled
      logic [DATA_W-1:0] rdata;                // Registered read data
   } state_s;

   state_s state_q;   // Registered state
   state_s state_d;   // Next state

   mmit_cmp_if cmp_bus ();   // Link to the comparator

   // Decoded write strobes, run gate and match
   logic wr_cmp_lo;    // Write to compare_low
   logic wr_cmp_hi;    // Write to compare_high
   logic wr_msk_lo;    // Write to ignore_bits_low
   logic wr_msk_hi;    // Write to ignore_bits_high
   logic wr_ctrl;      // Write to timer_control
   logic wr_cnt_lo;    // Write to count_low
   logic wr_cnt_hi;    // Write to count_high
   logic sw_cnt_wr;    // Any software write to the counter
   logic count_run;    // Counter advances this cycle
   logic match;        // Masked match this cycle

   // Operands to the masked comparator
   assign cmp_bus.count_value         = state_q.count;
   assign cmp_bus.compare_value       = state_q.compare_value;
   assign cmp_bus.compare_ignore_bits = state_q.compare_ignore_bits;
   assign match                       = cmp_bus.match;

   // Masked comparator, evaluated on every cycle
   mmit_masked_cmp u_cmp (
      .cmp_bus (cmp_bus.cmp)
   );

   // Address decode of the write strobe
   always_comb begin
      wr_cmp_lo = wr_i && (addr_i == OFS_COMPARE_LOW);
      wr_msk_lo = wr_i && (addr_i == OFS_IGNORE_BITS_LOW);
      wr_ctrl   = wr_i && (addr_i == OFS_TIMER_CONTROL);
      wr_cnt_lo = wr_i && (addr_i == OFS_COUNT_LOW);
      wr_cmp_hi = wr_i && (addr_i == OFS_COMPARE_HIGH);
      wr_msk_hi = wr_i && (addr_i == OFS_IGNORE_BITS_HIGH);
      wr_cnt_hi = wr_i && (addr_i == OFS_COUNT_HIGH);
      sw_cnt_wr = wr_cnt_lo || wr_cnt_hi;
   end

   // Counting is gated by enable and, if chosen, by debug halt
   always_comb begin
      count_run = state_q.count_enable
                  && !(state_q.debug_halt_stop && debug_halt_i);
   end

   // Next-state logic for every register of the block
   always_comb begin
      state_d = state_q;

      // Compare value halves
      if (wr_cmp_lo) begin
         state_d.compare_value[LOW_W-1:0] = wdata_i;
      end
      if (wr_cmp_hi) begin
         state_d.compare_value[CNT_W-1:LOW_W] = wdata_i[HIGH_W-1:0];
      end

      // Mask halves
      if (wr_msk_lo) begin
         state_d.compare_ignore_bits[LOW_W-1:0] = wdata_i;
      end
      if (wr_msk_hi) begin
         state_d.compare_ignore_bits[CNT_W-1:LOW_W] = wdata_i[HIGH_W-1:0];
      end

      // Control bits; upper bits are not stored
      if (wr_ctrl) begin
         state_d.clear_on_match  = wdata_i[CTRL_CLEAR_ON_MATCH_BIT];
         state_d.debug_halt_stop = wdata_i[CTRL_DEBUG_HALT_STOP_BIT];
         state_d.count_enable    = wdata_i[CTRL_COUNT_ENABLE_BIT];
      end

      // Flag: write one clears, a match in the same cycle wins
      if (wr_ctrl && wdata_i[CTRL_MATCH_FLAG_BIT]) begin
         state_d.match_flag = 1'b0;
      end
      if (match) begin
         state_d.match_flag = 1'b1;
      end

      // Counter: match clear, else increment when running
      if (match && state_q.clear_on_match) begin
         state_d.count = RST_COUNT;
      end else if (count_run) begin
         state_d.count = state_q.count + CNT_STEP;
      end

      // Software load of a counter half takes priority
      if (wr_cnt_lo) begin
         state_d.count[LOW_W-1:0] = wdata_i;
      end
      if (wr_cnt_hi) begin
         state_d.count[CNT_W-1:LOW_W] = wdata_i[HIGH_W-1:0];
      end

      // Read mux; unmapped addresses read zero
      state_d.rdata = '0;
      if (rd_i) begin
         case (addr_i)
            OFS_COMPARE_LOW: begin
               state_d.rdata = state_q.compare_value[LOW_W-1:0];
            end
            OFS_IGNORE_BITS_LOW: begin
               state_d.rdata = state_q.compare_ignore_bits[LOW_W-1:0];
            end
            OFS_TIMER_CONTROL: begin
               state_d.rdata[CTRL_MATCH_FLAG_BIT]      = state_q.match_flag;
               state_d.rdata[CTRL_CLEAR_ON_MATCH_BIT]  = state_q.clear_on_match;
               state_d.rdata[CTRL_DEBUG_HALT_STOP_BIT] = state_q.debug_halt_stop;
               state_d.rdata[CTRL_COUNT_ENABLE_BIT]    = state_q.count_enable;
            end
            OFS_COUNT_LOW: begin
               state_d.rdata = state_q.count[LOW_W-1:0];
            end
            OFS_COMPARE_HIGH: begin
               state_d.rdata[HIGH_W-1:0] = state_q.compare_value[CNT_W-1:LOW_W];
            end
            OFS_IGNORE_BITS_HIGH: begin
               state_d.rdata[HIGH_W-1:0] = state_q.compare_ignore_bits[CNT_W-1:LOW_W];
            end
            OFS_COUNT_HIGH: begin
               state_d.rdata[HIGH_W-1:0] = state_q.count[CNT_W-1:LOW_W];
            end
            default: begin
               state_d.rdata = '0;
            end
         endcase
      end
   end

   // State register with synchronous reset
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state_q.compare_value       <= {RST_COMPARE_HIGH, RST_COMPARE_LOW};
         state_q.compare_ignore_bits <= {RST_IGNORE_BITS_HIGH,
                                         RST_IGNORE_BITS_LOW};
         state_q.count               <= RST_COUNT;
         state_q.match_flag          <= RST_MATCH_FLAG;
         state_q.clear_on_match      <= RST_CLEAR_ON_MATCH;
         state_q.debug_halt_stop     <= RST_DEBUG_HALT_STOP;
         state_q.count_enable        <= RST_COUNT_ENABLE;
         state_q.rdata               <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   // Outputs straight from the state register
   assign rdata_o = state_q.rdata;
   assign irq_o   = state_q.match_flag;

   // Checks on the behaviour above, all on the main clock

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (srst_i);

   // Helper: cycles since reset release, saturating
   logic [3:0] since_rst_q;  // Counts edges after reset
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         since_rst_q <= 4'h0;
      end else if (since_rst_q != 4'hF) begin
         since_rst_q <= since_rst_q + 4'h1;
      end
   end

   // A quiet cycle: no counter load by software
   sequence s_no_load;
      !sw_cnt_wr;
   endsequence

   // A match while clear-on-match is set
   sequence s_clear_match;
      match && state_q.clear_on_match && !sw_cnt_wr;
   endsequence

   // Read request of count_low
   sequence s_read_count_low;
      rd_i && (addr_i == OFS_COUNT_LOW);
   endsequence

   // Match sets the flag at the next edge
   chk_flag_on_match: assert property (match |=> irq_o && state_q.match_flag)
      else $error("match flag not set after a match");

   // Clear-on-match zeroes the counter on the same edge as the flag
   chk_clear_same_edge: assert property (s_clear_match |=>
         (state_q.count == RST_COUNT) && state_q.match_flag)
      else $error("counter not cleared with flag on match");

   // Running counter advances by exactly one
   chk_count_advance: assert property (
         s_no_load ##0 (count_run && !(match && state_q.clear_on_match))
         |=> state_q.count == $past(state_q.count) + CNT_STEP)
      else $error("counter did not advance by one");

   // Debug halt with stop bit holds the count
   chk_halt_holds: assert property (
         state_q.debug_halt_stop && debug_halt_i && !sw_cnt_wr
         && !(match && state_q.clear_on_match)
         |=> $stable(state_q.count))
      else $error("counter moved during debug halt");

   // Disabled counter holds its value
   chk_enable_off: assert property (
         !state_q.count_enable && !sw_cnt_wr
         && !(match && state_q.clear_on_match)
         |=> $stable(state_q.count))
      else $error("counter moved while disabled");

   // Writing one clears the flag unless a new match arrives
   chk_flag_w1c: assert property (
         wr_ctrl && wdata_i[CTRL_MATCH_FLAG_BIT] && !match |=> !irq_o)
      else $error("match flag not cleared by write of one");

   // Writing zero leaves a set flag alone
   chk_flag_w0_keep: assert property (
         irq_o && wr_ctrl && !wdata_i[CTRL_MATCH_FLAG_BIT] |=> irq_o)
      else $error("match flag lost on write of zero");

   // Values seen on the first edge after reset release
   chk_reset_values: assert property (
         since_rst_q == 4'h0 |->
         state_q.count_enable && state_q.debug_halt_stop && !state_q.clear_on_match
         && (state_q.compare_value == {RST_COMPARE_HIGH, RST_COMPARE_LOW})
         && (state_q.compare_ignore_bits == {RST_IGNORE_BITS_HIGH, RST_IGNORE_BITS_LOW}))
      else $error("wrong values after reset");

   // Count read returns the value seen at the strobe
   chk_read_latency: assert property (
         s_read_count_low |=> rdata_o == $past(state_q.count[LOW_W-1:0]))
      else $error("count_low read data wrong");

   // Without clear-on-match a match does not disturb the count
   chk_no_clear_free: assert property (
         match && !state_q.clear_on_match && count_run && !sw_cnt_wr
         |=> state_q.count == $past(state_q.count) + CNT_STEP)
      else $error("match disturbed the count sequence");

   // Interrupt holds at every edge that brings no clearing write
   chk_irq_level: assert property (
         irq_o && !(wr_ctrl && wdata_i[CTRL_MATCH_FLAG_BIT]) |=> irq_o)
      else $error("interrupt dropped without a clear");

   // Flag never rises without a match behind it
   chk_flag_no_cause: assert property (
         !match && !irq_o |=> !irq_o)
      else $error("match flag set without a match");

   // Read data stand only in the cycle after a read strobe
   chk_rdata_idle: assert property (
         !rd_i |=> rdata_o == '0)
      else $error("read data not zero outside a read");

   // Control reads show zeros above the mode bits
   chk_ctrl_upper: assert property (
         rd_i && (addr_i == OFS_TIMER_CONTROL)
         |=> rdata_o[DATA_W-1:CTRL_COUNT_ENABLE_BIT+1] == '0)
      else $error("control read shows upper bits");

   // Software load of the low count half lands at the next edge
   chk_load_low: assert property (
         wr_cnt_lo |=> state_q.count[LOW_W-1:0] == $past(wdata_i))
      else $error("count_low write did not land");

   // Software load of the high count half lands at the next edge
   chk_load_high: assert property (
         wr_cnt_hi |=> state_q.count[CNT_W-1:LOW_W] == $past(wdata_i[HIGH_W-1:0]))
      else $error("count_high write did not land");

   // Low compare half takes the written word
   chk_compare_low: assert property (
         wr_cmp_lo |=> state_q.compare_value[LOW_W-1:0] == $past(wdata_i))
      else $error("compare_low write did not land");

   // High compare half takes the low bits of the written word
   chk_compare_high: assert property (
         wr_cmp_hi
         |=> state_q.compare_value[CNT_W-1:LOW_W] == $past(wdata_i[HIGH_W-1:0]))
      else $error("compare_high write did not land");

   // Low mask half takes the written word
   chk_mask_low: assert property (
         wr_msk_lo |=> state_q.compare_ignore_bits[LOW_W-1:0] == $past(wdata_i))
      else $error("ignore_bits_low write did not land");

   // High mask half takes the low bits of the written word
   chk_mask_high: assert property (
         wr_msk_hi
         |=> state_q.compare_ignore_bits[CNT_W-1:LOW_W] == $past(wdata_i[HIGH_W-1:0]))
      else $error("ignore_bits_high write did not land");

   // Control write sets the three mode bits at the next edge
   chk_ctrl_bits: assert property (
         wr_ctrl |=> (state_q.clear_on_match == $past(wdata_i[CTRL_CLEAR_ON_MATCH_BIT]))
         && (state_q.debug_halt_stop == $past(wdata_i[CTRL_DEBUG_HALT_STOP_BIT]))
         && (state_q.count_enable == $past(wdata_i[CTRL_COUNT_ENABLE_BIT])))
      else $error("control bits not taken from the write");

endmodule

// *** tb/test_masked_match_interval_timer.sv ***
// Self-checking testbench for the masked match interval timer
module test_masked_match_interval_timer
   import mmit_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              clk_sys_i;    // Main clock
   logic              srst_i;       // Synchronous reset
   logic [ADDR_W-1:0] addr_i;       // Register address
   logic [DATA_W-1:0] wdata_i;      // Register write data
   logic              wr_i;         // Write strobe
   logic              rd_i;         // Read strobe
   logic              debug_halt_i; // Debug halt level
   logic [DATA_W-1:0] rdata_o;      // Read data
   logic              irq_o;        // Interrupt level
   int                n_errors;     // Mismatches seen
   int                n_tests;      // Comparisons made

   masked_match_interval_timer DUT (
      .clk_sys_i    (clk_sys_i),
      .srst_i       (srst_i),
      .addr_i       (addr_i),
      .wdata_i      (wdata_i),
      .wr_i         (wr_i),
      .rd_i         (rd_i),
      .debug_halt_i (debug_halt_i),
      .rdata_o      (rdata_o),
      .irq_o        (irq_o)
   );

   // Clock at 100 MHz
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // Compares one value and counts the outcome
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One-cycle register write
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i    <= 1'b0;
   endtask

   // One-cycle register read, data taken in the following cycle
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk_sys_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i   <= 1'b0;
      #1 d = rdata_o;
   endtask

   // Reads a register and compares it
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] d;
      rd(a, d);
      check(d, exp);
   endtask

   // Checks the interrupt level two edges after the last write
   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge clk_sys_i);
      #1 check(DATA_W'(irq_o), DATA_W'(exp));
   endtask

   // Stops the counter, clears the flag and loads a 48-bit count
   task automatic stop_load(input logic [DATA_W-1:0] lo, input logic [DATA_W-1:0] hi);
      wr(OFS_TIMER_CONTROL, 32'h0000_0001);
      wr(OFS_COUNT_LOW, lo);
      wr(OFS_COUNT_HIGH, hi);
   endtask

   // Waits for the interrupt under a bounded count
   task automatic wait_irq();
      int i;
      for (i = 0; i < 40 && irq_o !== 1'b1; i++) begin
         @(posedge clk_sys_i);
         #1;
      end
      check(DATA_W'(irq_o), 32'h0000_0001);
   endtask

   // Reset values, unmapped place and the read data window
   task automatic t_reset();
      logic [DATA_W-1:0] d;
      rd(OFS_COUNT_LOW, d);
      check(DATA_W'(d < 32'h0000_0010), 32'h0000_0001);
      @(posedge clk_sys_i);
      #1 check(rdata_o, 32'h0000_0000);
      rd_chk(OFS_COMPARE_LOW, 32'hFFFF_FFFF);
      rd_chk(OFS_IGNORE_BITS_LOW, 32'h0000_0000);
      rd_chk(OFS_TIMER_CONTROL, 32'h0000_000C);
      rd_chk(OFS_COMPARE_HIGH, 32'h0000_FFFF);
      rd_chk(OFS_IGNORE_BITS_HIGH, 32'h0000_0000);
      rd_chk(OFS_COUNT_HIGH, 32'h0000_0000);
      wr(8'h18, 32'hA5A5_A5A5);
      rd_chk(8'h18, 32'h0000_0000);
   endtask

   // Count advance over two cycles for one enable and halt setting
   task automatic t_gate(input logic [3:0] ctrl, input logic halt, input logic [DATA_W-1:0] dlt);
      logic [DATA_W-1:0] a;
      logic [DATA_W-1:0] b;
      @(posedge clk_sys_i);
      debug_halt_i <= halt;
      wr(OFS_TIMER_CONTROL, {28'h000_0000, ctrl});
      rd(OFS_COUNT_LOW, a);
      rd(OFS_COUNT_LOW, b);
      check(b - a, dlt);
   endtask

   // Read and write of the compare and mask halves
   task automatic t_regs();
      wr(OFS_COMPARE_LOW, 32'h1234_5678);
      wr(OFS_COMPARE_HIGH, 32'hDEAD_BEEF);
      wr(OFS_IGNORE_BITS_LOW, 32'h8765_4321);
      wr(OFS_IGNORE_BITS_HIGH, 32'hFFFF_0F0F);
      rd_chk(OFS_COMPARE_LOW, 32'h1234_5678);
      rd_chk(OFS_COMPARE_HIGH, 32'h0000_BEEF);
      rd_chk(OFS_IGNORE_BITS_LOW, 32'h8765_4321);
      rd_chk(OFS_IGNORE_BITS_HIGH, 32'h0000_0F0F);
      wr(OFS_IGNORE_BITS_LOW, 32'h0000_0000);
      wr(OFS_IGNORE_BITS_HIGH, 32'h0000_0000);
   endtask

   // Stopped counter: exact match, masking in both halves, clear by one
   task automatic t_mask();
      stop_load(32'h0000_0055, 32'h0000_0000);
      wr(OFS_COMPARE_LOW, 32'h0000_0055);
      wr(OFS_COMPARE_HIGH, 32'h0000_0000);
      irq_chk(1'b1);
      rd_chk(OFS_TIMER_CONTROL, 32'h0000_0001);
      wr(OFS_COUNT_LOW, 32'h0000_0077);
      wr(OFS_TIMER_CONTROL, 32'h0000_0000);
      irq_chk(1'b1);
      wr(OFS_TIMER_CONTROL, 32'h0000_0001);
      irq_chk(1'b0);
      wr(OFS_IGNORE_BITS_LOW, 32'h0000_0022);
      irq_chk(1'b1);
      wr(OFS_COUNT_HIGH, 32'h0000_0001);
      wr(OFS_TIMER_CONTROL, 32'h0000_0001);
      irq_chk(1'b0);
      wr(OFS_IGNORE_BITS_HIGH, 32'h0000_0001);
      irq_chk(1'b1);
      wr(OFS_IGNORE_BITS_LOW, 32'h0000_0000);
      wr(OFS_IGNORE_BITS_HIGH, 32'h0000_0000);
   endtask

   // Running match with and without clear on match
   task automatic t_match(input logic clr);
      logic [DATA_W-1:0] d;
      stop_load(32'h0000_0100, 32'h0000_0000);
      wr(OFS_COMPARE_LOW, 32'h0000_0108);
      irq_chk(1'b0);
      wr(OFS_TIMER_CONTROL, {28'h000_0000, 1'b1, 1'b0, clr, 1'b0});
      wait_irq();
      wr(OFS_TIMER_CONTROL, {28'h000_0000, 2'b00, clr, 1'b0});
      rd(OFS_COUNT_LOW, d);
      if (clr) check(DATA_W'(d < 32'h0000_0010), 32'h0000_0001);
      else check(DATA_W'(d > 32'h0000_0108), 32'h0000_0001);
      rd_chk(OFS_COUNT_HIGH, 32'h0000_0000);
      rd_chk(OFS_TIMER_CONTROL, {28'h000_0000, 2'b00, clr, 1'b1});
   endtask

   // Carry from the low half and roll-over of the full count
   task automatic t_roll();
      logic [DATA_W-1:0] d;
      wr(OFS_COMPARE_LOW, 32'hFFFF_FFFF);
      wr(OFS_COMPARE_HIGH, 32'h0000_FFFF);
      stop_load(32'hFFFF_FFFE, 32'h0000_0000);
      wr(OFS_TIMER_CONTROL, 32'h0000_0008);
      wr(OFS_TIMER_CONTROL, 32'h0000_0000);
      rd_chk(OFS_COUNT_HIGH, 32'h0000_0001);
      stop_load(32'hFFFF_FFFE, 32'h0000_FFFF);
      wr(OFS_TIMER_CONTROL, 32'h0000_0008);
      wr(OFS_TIMER_CONTROL, 32'h0000_0000);
      rd_chk(OFS_COUNT_HIGH, 32'h0000_0000);
      rd(OFS_COUNT_LOW, d);
      check(DATA_W'(d < 32'h0000_0004), 32'h0000_0001);
   endtask

   // Prints the counts and the verdict, then ends the run
   task automatic results();
      $display("Comparisons: %0d  mismatches: %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Cuts a hang short well past the expected run length
   initial begin
      #200000;
      n_errors++;
      results();
   end

   // Main sequence
   initial begin
      n_errors     = 0;
      n_tests      = 0;
      srst_i       = 1'b1;
      addr_i       = '0;
      wdata_i      = '0;
      wr_i         = 1'b0;
      rd_i         = 1'b0;
      debug_halt_i = 1'b0;
      repeat (2) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      t_reset();
      t_gate(4'h8, 1'b1, 32'h0000_0002);
      t_gate(4'hC, 1'b1, 32'h0000_0000);
      t_gate(4'hC, 1'b0, 32'h0000_0002);
      t_gate(4'h4, 1'b0, 32'h0000_0000);
      t_regs();
      t_mask();
      t_match(1'b0);
      t_match(1'b1);
      t_roll();
      results();
   end
endmodule
